// [hdl/opwv_programmer.sv]
/*
  Programmer end: runs the write / verify / retry / extra-write loop and
  the read-out loop over the pin link, one 16-bit word as two bytes.
  Assumes the word to write is held on word_data_in while word_addr_out
  stands, and that the device is already powered in programming mode.
*/
`timescale 1ns/10ps
module opwv_programmer
  import opwv_pkg::*;
#(
  parameter int WRITE_CYCLES = OPWV_WRITE_CYC
)
(
  input  wire logic   sys_clk_in,
  input  wire logic   nrst_in,
  opwv_link_if.host   link,
  input  wire logic   start_in,
  input  wire logic   read_in,
  input  wire logic [15:0] word_data_in,
  output logic [9:0]  word_addr_out,
  output logic [15:0] rd_data_out,
  output logic        rd_valid_out,
  output logic        busy_out,
  output logic        done_out,
  output logic        fail_out
);

  // ----------------------------------------------------------------
  // State and working registers
  // ----------------------------------------------------------------
  opwv_state_t          st_q, st_d;
  opwv_state_t          nxt_q, nxt_d;
  logic [OPWV_TMR_W-1:0] tmr_q, tmr_d;
  logic [4:0]           tries_q, tries_d;
  logic [4:0]           xcnt_q, xcnt_d;
  logic [9:0]           addr_q, addr_d;
  logic                 half_q, half_d;
  logic                 rd_q, rd_d;
  logic [1:0]           pls_q, pls_d;
  logic                 pclk_d;
  logic [7:0]           lo_q, lo_d;
  logic [15:0]          rdw_d;
  logic                 rdv_d;
  logic                 done_d, fail_d;
  logic [3:0]           mode_d;

  wire                  tmr_zero = (tmr_q == '0);
  wire [7:0]            exp_byte = half_q ? word_data_in[15:8] : word_data_in[7:0];
  wire                  match    = (link.prog_data_port == exp_byte);
  wire                  last_pls = (pls_q == OPWV_PLS_LAST);
  wire                  last_adr = (addr_q == OPWV_ADDR_LAST);
  wire [OPWV_TMR_W-1:0] t_write  = OPWV_TMR_W'(WRITE_CYCLES - 1);
  wire [OPWV_TMR_W-1:0] t_settle = OPWV_TMR_W'(OPWV_SETTLE_CYC - 1);
  wire [OPWV_TMR_W-1:0] t_phalf  = OPWV_TMR_W'(OPWV_PHALF_CYC - 1);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Every leg but idle first waits out its timer, then picks the next leg
  always_comb
  begin
    st_d    = st_q;
    nxt_d   = nxt_q;
    tmr_d   = tmr_zero ? tmr_q : tmr_q - 1'b1;
    tries_d = tries_q;
    xcnt_d  = xcnt_q;
    addr_d  = addr_q;
    half_d  = half_q;
    rd_d    = rd_q;
    pls_d   = pls_q;
    pclk_d  = link.prog_clk;
    lo_d    = lo_q;
    rdw_d   = rd_data_out;
    rdv_d   = 1'b0;
    done_d  = done_out;
    fail_d  = fail_out;
    case (st_q)
      OPWV_S_IDLE:
        if (start_in)
        begin
          st_d    = OPWV_S_CLR;
          tmr_d   = t_settle;
          rd_d    = read_in;
          addr_d  = OPWV_ADDR_RST;
          half_d  = 1'b0;
          tries_d = 5'h00;
          done_d  = 1'b0;
          fail_d  = 1'b0;
        end
      OPWV_S_CLR:
        if (tmr_zero)
        begin
          st_d  = OPWV_S_INH;
          nxt_d = rd_q ? OPWV_S_VFY : OPWV_S_WR;
          tmr_d = t_settle;
        end
      OPWV_S_INH:
        if (tmr_zero)
        begin
          st_d  = nxt_q;
          tmr_d = (nxt_q == OPWV_S_PLS) ? t_phalf
                : (nxt_q == OPWV_S_VFY) ? t_settle : t_write;
        end
      OPWV_S_WR:
        if (tmr_zero)
        begin
          tries_d = tries_q + 5'h01;
          st_d    = OPWV_S_INH;
          nxt_d   = OPWV_S_VFY;
          tmr_d   = t_settle;
        end
      OPWV_S_VFY:
        if (tmr_zero)
        begin
          if (rd_q)
          begin
            // Low byte waits for its partner; high byte completes the word
            if (!half_q)
              lo_d = link.prog_data_port;
            else
            begin
              rdw_d = {link.prog_data_port, lo_q};
              rdv_d = 1'b1;
            end
            st_d  = OPWV_S_PLS;
            tmr_d = t_phalf;
          end
          else if (match)
          begin
            xcnt_d = tries_q;
            st_d   = OPWV_S_INH;
            nxt_d  = OPWV_S_XWR;
            tmr_d  = t_settle;
          end
          else if (tries_q == OPWV_RETRY_MAX)
          begin
            fail_d = 1'b1;                               // Bounded to avoid hanging
            st_d   = OPWV_S_END_INH;
            tmr_d  = t_settle;
          end
          else
          begin
            st_d  = OPWV_S_INH;
            nxt_d = OPWV_S_WR;
            tmr_d = t_settle;
          end
        end
      OPWV_S_XWR:
        if (tmr_zero)
        begin
          if (xcnt_q > 5'h01)
          begin
            xcnt_d = xcnt_q - 5'h01;
            tmr_d  = t_write;
          end
          else
          begin
            st_d  = OPWV_S_INH;
            nxt_d = OPWV_S_PLS;
            tmr_d = t_settle;
          end
        end
      OPWV_S_PLS:
        if (tmr_zero)
        begin
          pclk_d = ~link.prog_clk;
          pls_d  = pls_q + 2'h1;
          tmr_d  = t_phalf;
          if (last_pls)
          begin
            // Two pulses per byte, four per word
            half_d  = ~half_q;
            tries_d = 5'h00;
            if (half_q && last_adr)
            begin
              st_d  = OPWV_S_END_INH;
              tmr_d = t_settle;
            end
            else
            begin
              if (half_q)
                addr_d = addr_q + 10'h001;
              // Inhibit dwell lets the new word settle before any burn
              st_d  = OPWV_S_INH;
              nxt_d = rd_q ? OPWV_S_VFY : OPWV_S_WR;
              tmr_d = t_settle;
            end
          end
        end
      OPWV_S_END_INH:
        if (tmr_zero)
        begin
          st_d  = OPWV_S_END_CLR;
          tmr_d = t_settle;
        end
      OPWV_S_END_CLR:
        if (tmr_zero)
        begin
          st_d   = OPWV_S_IDLE;
          done_d = 1'b1;
        end
      default:
        st_d = OPWV_S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin mode from the next state
  // ----------------------------------------------------------------
  // Taken from st_d so mode pins and data drive change in the same edge
  wire sel_clr = (st_d == OPWV_S_CLR) || (st_d == OPWV_S_END_CLR);
  wire sel_wr  = (st_d == OPWV_S_WR) || (st_d == OPWV_S_XWR);
  wire sel_vfy = (st_d == OPWV_S_VFY) || ((st_d == OPWV_S_PLS) && rd_d);
  assign mode_d = sel_clr ? OPWV_MD_CLR
                : sel_wr  ? OPWV_MD_WR
                : sel_vfy ? OPWV_MD_VFY : OPWV_MD_INH;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Pin clock resets low so the device sees no stray pulse
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      st_q    <= OPWV_S_IDLE;
      nxt_q   <= OPWV_S_INH;
      tmr_q   <= '0;
      tries_q <= 5'h00;
      xcnt_q  <= 5'h00;
      addr_q  <= OPWV_ADDR_RST;
      half_q  <= 1'b0;
      rd_q    <= 1'b0;
      pls_q   <= 2'h0;
      lo_q    <= 8'h00;
    end
    else
    begin
      st_q    <= st_d;
      nxt_q   <= nxt_d;
      tmr_q   <= tmr_d;
      tries_q <= tries_d;
      xcnt_q  <= xcnt_d;
      addr_q  <= addr_d;
      half_q  <= half_d;
      rd_q    <= rd_d;
      pls_q   <= pls_d;
      lo_q    <= lo_d;
    end

  // Pin and user-side outputs, all straight from flops
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      link.prog_clk         <= 1'b0;
      link.mode_select_pins <= OPWV_MD_INH;
      link.host_do          <= 8'h00;
      link.host_oe          <= 1'b0;
      word_addr_out         <= OPWV_ADDR_RST;
      rd_data_out           <= 16'h0000;
      rd_valid_out          <= 1'b0;
      busy_out              <= 1'b0;
      done_out              <= 1'b0;
      fail_out              <= 1'b0;
    end
    else
    begin
      link.prog_clk         <= pclk_d;
      link.mode_select_pins <= mode_d;
      link.host_do          <= half_d ? word_data_in[15:8] : word_data_in[7:0];
      link.host_oe          <= sel_wr;
      word_addr_out         <= addr_d;
      rd_data_out           <= rdw_d;
      rd_valid_out          <= rdv_d;
      busy_out              <= (st_d != OPWV_S_IDLE);
      done_out              <= done_d;
      fail_out              <= fail_d;
    end

endmodule

// [hdl/opwv_pkg.sv]
/*
  Shared constants and types for the one-time PROM program/verify link:
  mode codes on the mode-select pins, geometry of the store, timing counts.
  Assumes a single 20 MHz system clock on both ends of the link.
*/
package opwv_pkg;

  // ----------------------------------------------------------------
  // Store geometry
  // ----------------------------------------------------------------
  localparam int          OPWV_WORDS     = 1024;
  localparam int          OPWV_AW        = 10;
  localparam int          OPWV_WW        = 16;
  localparam int          OPWV_BW        = 8;
  localparam logic [9:0]  OPWV_ADDR_RST  = 10'h000;
  localparam logic [9:0]  OPWV_ADDR_LAST = 10'h3FF;
  localparam logic [15:0] OPWV_ERASED    = 16'hFFFF;
  localparam logic [1:0]  OPWV_PH_LAST   = 2'h3;   // Fourth pulse of an address cycle

  // ----------------------------------------------------------------
  // Mode-select pin codes, bit0 = first pin
  // ----------------------------------------------------------------
  localparam logic [3:0]  OPWV_MD_CLR    = 4'h5;   // H L H L
  localparam logic [3:0]  OPWV_MD_WR     = 4'hE;   // L H H H
  localparam logic [3:0]  OPWV_MD_VFY    = 4'hC;   // L L H H
  localparam logic [3:0]  OPWV_MD_INH    = 4'hD;   // H x H H, x driven low
  localparam logic [3:0]  OPWV_INH_MASK  = 4'hD;   // Bit1 ignored for inhibit

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          OPWV_CLK_NS    = 50;
  localparam int          OPWV_WRITE_US  = 1000;
  localparam int          OPWV_WRITE_CYC = (OPWV_WRITE_US * 1000 + OPWV_CLK_NS - 1) / OPWV_CLK_NS;
  localparam int          OPWV_PHALF_NS  = 500;    // Half period of the pin clock
  localparam int          OPWV_PHALF_CYC = (OPWV_PHALF_NS + OPWV_CLK_NS - 1) / OPWV_CLK_NS;
  localparam int          OPWV_SETTLE_NS = 1000;   // Dwell in each mode before acting
  localparam int          OPWV_SETTLE_CYC = (OPWV_SETTLE_NS + OPWV_CLK_NS - 1) / OPWV_CLK_NS;
  localparam int          OPWV_TMR_W     = 15;
  localparam logic [4:0]  OPWV_RETRY_MAX = 5'h19;  // Give up after this many attempts
  localparam logic [1:0]  OPWV_PLS_LAST  = 2'h3;   // Four edges make two pulses

  // ----------------------------------------------------------------
  // Programmer sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OPWV_S_IDLE    = 4'b0000,
    OPWV_S_CLR     = 4'b0001,
    OPWV_S_INH     = 4'b0010,
    OPWV_S_WR      = 4'b0011,
    OPWV_S_VFY     = 4'b0100,
    OPWV_S_XWR     = 4'b0101,
    OPWV_S_PLS     = 4'b0110,
    OPWV_S_END_INH = 4'b0111,
    OPWV_S_END_CLR = 4'b1000
  } opwv_state_t;

endpackage

// [hdl/opwv_link_if.sv]
/*
  Pin-level link between the external programmer and the PROM device:
  pin clock, mode-select pins and the shared 8-bit data port.
  Assumes unused data pins are pulled low when neither end drives them.
*/
`timescale 1ns/10ps
interface opwv_link_if;

  logic       prog_clk;          // Address pin clock, low at rest
  logic [3:0] mode_select_pins;
  logic [7:0] host_do;
  logic       host_oe;
  logic [7:0] dev_do;
  logic       dev_oe;
  logic [7:0] prog_data_port;    // Resolved pin level

  // Resolve the shared port; pull-down when idle
  assign prog_data_port = host_oe ? host_do : (dev_oe ? dev_do : 8'h00);

  modport host (
    output prog_clk,
    output mode_select_pins,
    output host_do,
    output host_oe,
    input  prog_data_port
  );

  modport dev (
    input  prog_clk,
    input  mode_select_pins,
    input  prog_data_port,
    output dev_do,
    output dev_oe
  );

endinterface

// [hdl/opwv_device.sv]
/*
  Device end: OTP program store with its sequential address counter,
  mode decode and byte-wide write/verify port.
  Assumes the pin clock and mode pins are synchronous to sys_clk_in.
*/
`timescale 1ns/10ps
module opwv_device
  import opwv_pkg::*;
(
  input  wire logic  sys_clk_in,
  input  wire logic  nrst_in,
  opwv_link_if.dev   link,
  output logic [9:0] cur_addr_out,
  output logic       wr_active_out
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire       md_clr = (link.mode_select_pins == OPWV_MD_CLR);
  wire       md_wr  = (link.mode_select_pins == OPWV_MD_WR);
  wire       md_vfy = (link.mode_select_pins == OPWV_MD_VFY);
  wire       md_inh = ((link.mode_select_pins & OPWV_INH_MASK) == OPWV_MD_INH);

  logic       pclk_prev_q;
  logic [9:0] addr_q;
  logic [1:0] ph_q;
  wire        pclk_rise = link.prog_clk & ~pclk_prev_q;
  wire        hi_half   = ph_q[1];

  // ----------------------------------------------------------------
  // Address counter: four pin pulses per word
  // ----------------------------------------------------------------
  // Clear wins over a pulse; pulses count in every other mode
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      pclk_prev_q <= 1'b0;
      addr_q      <= OPWV_ADDR_RST;
      ph_q        <= 2'h0;
    end
    else
    begin
      pclk_prev_q <= link.prog_clk;
      if (md_clr)
      begin
        addr_q <= OPWV_ADDR_RST;
        ph_q   <= 2'h0;
      end
      else if (pclk_rise)
      begin
        ph_q <= ph_q + 2'h1;
        if (ph_q == OPWV_PH_LAST)
          addr_q <= addr_q + 10'h001;
      end
    end

  // ----------------------------------------------------------------
  // Store: 1024 x 16, cells only ever move from 1 to 0
  // ----------------------------------------------------------------
  logic [15:0]   mem [0:OPWV_WORDS-1];
  logic [1023:0] used_q;                          // Word has been written once
  wire  [15:0]   cur_word = used_q[addr_q] ? mem[addr_q] : OPWV_ERASED;
  wire  [7:0]    wr_byte  = link.prog_data_port;
  wire  [15:0]   new_word = hi_half ? {cur_word[15:8] & wr_byte, cur_word[7:0]}
                                    : {cur_word[15:8], cur_word[7:0] & wr_byte};
  wire  [7:0]    rd_byte  = hi_half ? cur_word[15:8] : cur_word[7:0];

  // Burn every cycle of write mode; extra writes simply re-burn the same zeros
  always_ff @(posedge sys_clk_in)
    if (md_wr)
      mem[addr_q] <= new_word;

  // Flags only model an erased part after reset; real cells keep their state
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      used_q <= '0;
    else if (md_wr)
      used_q[addr_q] <= 1'b1;

  // ----------------------------------------------------------------
  // Port drive and user-side status
  // ----------------------------------------------------------------
  // Drive only in verify; inhibit and write leave the port to the programmer
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      link.dev_do   <= 8'h00;
      link.dev_oe   <= 1'b0;
      cur_addr_out  <= OPWV_ADDR_RST;
      wr_active_out <= 1'b0;
    end
    else
    begin
      link.dev_do   <= rd_byte;
      link.dev_oe   <= md_vfy & ~md_inh;
      cur_addr_out  <= addr_q;
      wr_active_out <= md_wr;
    end

endmodule

// [dv/opwv_asserts.sv]
/*
  Checker for the pin link between programmer and device ends.
  Assumes one clock domain and the link signals handed in by name.
*/
`timescale 1ns/10ps
module opwv_asserts
  import opwv_pkg::*;
#(
  parameter int WRITE_CYCLES = 20
)
(
  input wire logic       sys_clk_in,
  input wire logic       nrst_in,
  input wire logic       prog_clk,
  input wire logic [3:0] mode_select_pins,
  input wire logic       host_oe,
  input wire logic       dev_oe,
  input wire logic [9:0] cur_addr_out
);

  // ----------------------------------------------------------------
  // Helper decode and counters
  // ----------------------------------------------------------------
  logic        clk_q;
  logic [9:0]  addr_q;
  logic [2:0]  pls_q;
  logic [2:0]  pls_d;
  logic [15:0] run_q;
  logic [15:0] run_d;
  wire         in_clr = (mode_select_pins == OPWV_MD_CLR);
  wire         in_wr  = (mode_select_pins == OPWV_MD_WR);
  wire         in_vfy = (mode_select_pins == OPWV_MD_VFY);
  wire         in_inh = (mode_select_pins == OPWV_MD_INH);
  wire         rise   = prog_clk && !clk_q;
  wire         moved  = (cur_addr_out != addr_q);

  // Pulses since the last address move; clear mode restarts the count
  assign pls_d = (in_clr || moved) ? 3'h0 : (rise ? pls_q + 3'h1 : pls_q);
  // Length of the current write mode run, cut back to zero outside it
  assign run_d = in_wr ? run_q + 16'h0001 : 16'h0000;

  // Helper registers, sampled like the device samples its pins
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      clk_q  <= 1'b0;
      addr_q <= OPWV_ADDR_RST;
      pls_q  <= 3'h0;
      run_q  <= 16'h0000;
    end
    else
    begin
      clk_q  <= prog_clk;
      addr_q <= cur_addr_out;
      pls_q  <= pls_d;
      run_q  <= run_d;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_fourth_rise;
    rise && (pls_q == 3'h3) && !in_clr;
  endsequence

  sequence s_write_end;
    in_wr ##1 !in_wr;
  endsequence

  a_verify_drives_port: assert property (1'b1 |=> (dev_oe == ($past(mode_select_pins) == OPWV_MD_VFY)))
    else $error("device drive does not follow verify mode");
  a_host_owns_write: assert property (in_wr |-> host_oe && !dev_oe)
    else $error("port not driven by the programmer alone in write mode");
  a_clear_zeroes_addr: assert property (in_clr [*3] |-> cur_addr_out == OPWV_ADDR_RST)
    else $error("address not zero in clear mode");
  a_addr_step_one: assert property (moved |-> (cur_addr_out == addr_q + 10'h001) || (cur_addr_out == OPWV_ADDR_RST))
    else $error("address moved by other than one");
  a_four_pulses_only: assert property (moved && !in_clr |-> pls_q == 3'h4)
    else $error("address moved without four pulses");
  a_fourth_advances: assert property (s_fourth_rise |-> ##[1:4] moved)
    else $error("fourth pulse did not advance the address");
  a_clk_rests_low: assert property (!in_vfy && !in_inh |-> !prog_clk)
    else $error("pin clock high outside inhibit or verify");
  a_inhibit_between: assert property ((mode_select_pins != $past(mode_select_pins)) && ($past(mode_select_pins) != OPWV_MD_INH) |-> in_inh)
    else $error("mode change without inhibit between");
  a_write_period: assert property (s_write_end |-> (run_q != 16'h0000) && ((run_q % WRITE_CYCLES) == 0))
    else $error("write period not a whole number of write times");

endmodule

// [dv/otp_program_write_verify_tb_top.sv]
/*
  Testbench: programmer and device joined on one link, plus a second
  device driven directly by the bench. Assumes blank store after reset.
*/
`timescale 1ns/10ps
module otp_program_write_verify_tb_top
  import opwv_pkg::*;
;
  localparam int WR_CYC = 20;
  localparam int N_WR   = 40;
  localparam int N_RD   = 64;

  logic        sys_clk_in, nrst_in, start_in, read_in, rd_pass, b_smp, vfy_q;
  logic        rd_valid_out, busy_out, done_out, fail_out, wr_active_out, wr_active_b;
  logic [15:0] word_data_in, rd_data_out, nxt;
  logic [9:0]  word_addr_out, cur_addr_out, cur_addr_b, last_addr;
  logic [7:0]  port_q;
  logic [15:0] tbl [OPWV_WORDS];
  logic [15:0] exp_q[$];
  logic [15:0] exp_b[$];
  int          bad_count, total_checks, seed, rd_seen, n;

  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  opwv_link_if i_opwv_link_if ();
  opwv_link_if i_opwv_link_if_b ();
  wire [3:0] mode_a = i_opwv_link_if.mode_select_pins;

  opwv_programmer #(.WRITE_CYCLES(WR_CYC)) i_opwv_programmer (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(i_opwv_link_if),
    .start_in(start_in), .read_in(read_in), .word_data_in(word_data_in),
    .word_addr_out(word_addr_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .busy_out(busy_out), .done_out(done_out), .fail_out(fail_out));
  opwv_device i_opwv_device (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .link(i_opwv_link_if), .cur_addr_out(cur_addr_out), .wr_active_out(wr_active_out));
  opwv_device i_opwv_device_b (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .link(i_opwv_link_if_b), .cur_addr_out(cur_addr_b), .wr_active_out(wr_active_b));
  opwv_asserts #(.WRITE_CYCLES(WR_CYC)) i_opwv_asserts (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .prog_clk(i_opwv_link_if.prog_clk), .mode_select_pins(mode_a),
    .host_oe(i_opwv_link_if.host_oe), .dev_oe(i_opwv_link_if.dev_oe),
    .cur_addr_out(cur_addr_out));

  always #25 sys_clk_in = ~sys_clk_in;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A wait that used up its bound ends the run
  task guard(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      bad_count++;
      $display("mismatch at %0t: wait ran out", $time);
      close_out();
    end
  endtask

  // Second device: the bench plays the programmer, rules bent on purpose
  task b_hold(input logic [3:0] md, input logic [7:0] d, input logic oe, input int cyc);
    i_opwv_link_if_b.mode_select_pins = md;
    i_opwv_link_if_b.host_do = d;
    i_opwv_link_if_b.host_oe = oe;
    repeat (cyc) @(negedge sys_clk_in);
  endtask

  task b_pulse(input int cnt);
    repeat (cnt)
    begin
      i_opwv_link_if_b.prog_clk = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      i_opwv_link_if_b.prog_clk = 1'b0;
      repeat (3) @(negedge sys_clk_in);
    end
  endtask

  task b_expect(input logic [7:0] a, input logic [7:0] d);
    exp_b.push_back({a, d});
    b_smp = 1'b1;
    @(negedge sys_clk_in);
    b_smp = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Monitor: oldest note against each result as it appears
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (nrst_in === 1'b1 && b_smp === 1'b1)
    begin
      nxt = (exp_b.size() > 0) ? exp_b.pop_front() : 16'hxxxx;
      chk({cur_addr_b[7:0], i_opwv_link_if_b.prog_data_port}, nxt);
    end
    if (nrst_in === 1'b1 && rd_pass === 1'b0 && vfy_q === 1'b1 && mode_a !== OPWV_MD_VFY)
    begin
      nxt = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      chk({8'h00, port_q}, nxt);
    end
    if (nrst_in === 1'b1 && rd_valid_out === 1'b1)
    begin
      rd_seen++;
      nxt = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      chk(rd_data_out, nxt);
    end
    vfy_q = (mode_a === OPWV_MD_VFY);
    port_q = i_opwv_link_if.prog_data_port;
  end

  // Word source: random word per address, two byte notes each
  always @(negedge sys_clk_in)
    if (rd_pass === 1'b0 && busy_out === 1'b1 && word_addr_out !== last_addr)
    begin
      last_addr = word_addr_out;
      word_data_in <= tbl[word_addr_out];
      exp_q.push_back({8'h00, tbl[word_addr_out][7:0]});
      exp_q.push_back({8'h00, tbl[word_addr_out][15:8]});
    end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk_in = 1'b0;
    nrst_in = 1'b0;
    start_in = 1'b0;
    read_in = 1'b0;
    rd_pass = 1'b0;
    b_smp = 1'b0;
    last_addr = 10'h000;
    i_opwv_link_if_b.prog_clk = 1'b0;
    b_hold(OPWV_MD_INH, 8'h00, 1'b0, 0);
    seed = 31478;
    for (n = 0; n < OPWV_WORDS; n++)
      tbl[n] = 16'($random(seed));
    word_data_in = tbl[0];
    repeat (8) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    // Direct decode, burn and address checks on the second device
    b_hold(OPWV_MD_CLR, 8'h00, 1'b0, 3);
    b_hold(OPWV_MD_INH, 8'h00, 1'b0, 3);
    b_hold(OPWV_MD_WR, 8'hA5, 1'b1, 4);
    chk({15'h0000, wr_active_b}, 16'h0001);
    b_hold(OPWV_MD_INH, 8'h00, 1'b0, 2);
    b_hold(4'hF, 8'h00, 1'b1, 4);
    b_hold(4'h0, 8'h00, 1'b1, 4);
    b_hold(OPWV_MD_VFY, 8'h00, 1'b0, 4);
    b_expect(8'h00, 8'hA5);
    b_hold(4'h0, 8'h00, 1'b0, 3);
    b_expect(8'h00, 8'h00);
    b_hold(OPWV_MD_WR, 8'h0F, 1'b1, 3);
    b_hold(OPWV_MD_INH, 8'h00, 1'b0, 2);
    b_hold(OPWV_MD_VFY, 8'h00, 1'b0, 3);
    b_expect(8'h00, 8'h05);
    b_hold(OPWV_MD_INH, 8'h00, 1'b0, 2);
    b_pulse(2);
    b_hold(OPWV_MD_WR, 8'h3C, 1'b1, 3);
    b_hold(OPWV_MD_INH, 8'h00, 1'b0, 2);
    b_hold(OPWV_MD_VFY, 8'h00, 1'b0, 3);
    b_expect(8'h00, 8'h3C);
    b_pulse(1);
    b_expect(8'h00, 8'h3C);
    b_pulse(1);
    b_expect(8'h01, 8'hFF);
    b_hold(OPWV_MD_CLR, 8'h00, 1'b0, 3);
    b_pulse(4);
    b_hold(OPWV_MD_INH, 8'h00, 1'b0, 2);
    b_hold(OPWV_MD_VFY, 8'h00, 1'b0, 3);
    b_expect(8'h00, 8'h05);
    b_pulse(2);
    b_expect(8'h00, 8'h3C);
    // Write pass over the first addresses, a refused start in mid-pass
    exp_q.push_back({8'h00, tbl[0][7:0]});
    exp_q.push_back({8'h00, tbl[0][15:8]});
    start_in = 1'b1;
    for (n = 0; n < 50 && busy_out !== 1'b1; n++)
      @(negedge sys_clk_in);
    guard(n, 50);
    start_in = 1'b0;
    for (n = 0; n < 5000 && word_addr_out !== 10'h005; n++)
      @(negedge sys_clk_in);
    guard(n, 5000);
    start_in = 1'b1;
    read_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    start_in = 1'b0;
    read_in = 1'b0;
    for (n = 0; n < 30000 && word_addr_out !== 10'(N_WR); n++)
      @(negedge sys_clk_in);
    guard(n, 30000);
    repeat (2) @(negedge sys_clk_in);
    chk(16'(exp_q.size()), 16'h0002);
    chk({14'h0000, done_out, fail_out}, 16'h0000);
    // Reset in mid-pass, then a read pass over the blank store
    nrst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk({6'h00, cur_addr_out}, 16'h0000);
    chk({9'h000, mode_a, i_opwv_link_if.prog_clk, i_opwv_link_if.dev_oe, busy_out},
        {9'h000, OPWV_MD_INH, 3'b000});
    exp_q.delete();
    rd_pass = 1'b1;
    rd_seen = 0;
    repeat (N_RD) exp_q.push_back(OPWV_ERASED);
    nrst_in = 1'b1;
    start_in = 1'b1;
    read_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    start_in = 1'b0;
    for (n = 0; n < 20000 && rd_seen < N_RD; n++)
      @(negedge sys_clk_in);
    guard(n, 20000);
    close_out();
  end

endmodule
